/* hw/fifo_port_cfg.svh */
// Offsets, field positions, reset values and timing counts of the
// endpoint FIFO access port. Assumes a 4 ns device clock.
`ifndef FIFO_PORT_CFG_SVH
`define FIFO_PORT_CFG_SVH

// Register offsets on the processor bus
`define FP_OFS_LEN 8'h1c
`define FP_OFS_FILL 8'h1e
`define FP_OFS_WINDOW 8'h20

// Reset values
`define FP_LEN_RST 16'h0000
`define FP_WINDOW_RST 16'h0000

// Fill status field and the control endpoint indices below this bound
`define FP_FILL_LSB 0
`define FP_FILL_W 2
`define FP_CTRL_EPS 2

// Processor wait times, kept here for the firmware side
`define FP_CLK_NS 4
`define FP_IDX_RD_NS 190
`define FP_IDX_WR_NS 100
`define FP_FILL_WAIT_NS 200
`define FP_IDX_RD_CYC ((`FP_IDX_RD_NS + `FP_CLK_NS - 1) / `FP_CLK_NS)
`define FP_IDX_WR_CYC ((`FP_IDX_WR_NS + `FP_CLK_NS - 1) / `FP_CLK_NS)
`define FP_FILL_WAIT_CYC ((`FP_FILL_WAIT_NS + `FP_CLK_NS - 1) / `FP_CLK_NS)

`endif

/* hw/fifo_port_pkg.sv */
// Types shared by the endpoint FIFO access port modules.
// Assumes the endpoint index carries the direction in its lowest bit.
package fifo_port_pkg;

  typedef logic [15:0] word_t;

  // Odd endpoint index is a transmit (IN) endpoint
  typedef enum logic {
    EP_DIR_OUT = 1'b0,
    EP_DIR_IN = 1'b1
  } ep_dir_e;

endpackage : fifo_port_pkg

/* hw/fifo_byte_ram.sv */
// Byte-wide endpoint buffer memory with a processor port and a USB port.
// Assumes the two ports never touch the same byte in one cycle.
`timescale 1ns/1ns
module fifo_byte_ram import fifo_port_pkg::*; #(
  parameter int AW = 15
) (
  input wire logic clk,
  input wire logic [AW-1:0] c_addr,
  input wire logic c_we,
  input wire logic c_two,
  input wire logic [15:0] c_wdata,
  output logic [15:0] c_rdata,
  input wire logic [AW-1:0] u_addr,
  input wire logic u_we,
  input wire logic [7:0] u_wdata,
  output logic [7:0] u_rdata
);

  logic [7:0] mem [2**AW];
  logic [AW-1:0] c_addr1;

  assign c_addr1 = AW'(c_addr + 1'b1);

  ////////////////////////////////////////////////////////////////////
  // Writes; no reset, contents are only valid below the byte count
  always_ff @(posedge clk) begin
    if (c_we) begin
      mem[c_addr] <= c_wdata[7:0];
      if (c_two) begin
        mem[c_addr1] <= c_wdata[15:8];
      end
    end
    if (u_we) begin
      mem[u_addr] <= u_wdata;
    end
  end

  // Asynchronous reads; the caller registers them
  assign c_rdata = {mem[c_addr1], mem[c_addr]};
  assign u_rdata = mem[u_addr];

endmodule : fifo_byte_ram

/* hw/ep_buffer_tracker.sv */
// Per-endpoint double buffer bookkeeping: fill count and the half that
// each side works in. Assumes at most one event per side per cycle.
`timescale 1ns/1ns
module ep_buffer_tracker import fifo_port_pkg::*; #(
  parameter int NUM_EP = 8,
  parameter int EPW = 3
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic usb_bus_rst,
  input wire logic [EPW-1:0] cpu_ep,
  input wire logic cpu_ev,
  input wire logic [EPW-1:0] usb_ep,
  input wire logic usb_ev,
  output logic [1:0] cpu_fill,
  output logic cpu_half,
  output logic [1:0] usb_fill,
  output logic usb_half
);

  logic [1:0] fill_q [NUM_EP];
  logic cpu_half_q [NUM_EP];
  logic usb_half_q [NUM_EP];

  // Net buffer count after this cycle's producer and consumer events
  function automatic logic [1:0] next_fill(
    input logic [1:0] f,
    input logic c_hit,
    input logic u_hit,
    input logic is_in
  );
    logic [1:0] n;
    n = f;
    if (c_hit) begin
      n = is_in ? n + 2'h1 : n - 2'h1;
    end
    if (u_hit) begin
      n = is_in ? n - 2'h1 : n + 2'h1;
    end
    return n;
  endfunction : next_fill

  ////////////////////////////////////////////////////////////////////
  // Producer adds a buffer, consumer removes one; both may hit one ep
  always_ff @(posedge clk) begin
    for (int e = 0; e < NUM_EP; e++) begin
      if (sys_rst || usb_bus_rst) begin
        fill_q[e] <= 2'h0;
        cpu_half_q[e] <= 1'b0;
        usb_half_q[e] <= 1'b0;
      end else begin
        fill_q[e] <= next_fill(fill_q[e], cpu_ev && cpu_ep == EPW'(e),
          usb_ev && usb_ep == EPW'(e), ep_dir_e'(e[0]) == EP_DIR_IN);
        if (cpu_ev && cpu_ep == EPW'(e)) begin
          cpu_half_q[e] <= !cpu_half_q[e];
        end
        if (usb_ev && usb_ep == EPW'(e)) begin
          usb_half_q[e] <= !usb_half_q[e];
        end
      end
    end
  end

  assign cpu_fill = fill_q[cpu_ep];
  assign cpu_half = cpu_half_q[cpu_ep];
  assign usb_fill = fill_q[usb_ep];
  assign usb_half = usb_half_q[usb_ep];

endmodule : ep_buffer_tracker

/* hw/endpoint_fifo_port.sv */
// Processor access path into the endpoint FIFOs: data window, packet
// length register and double buffer fill status, plus the USB side
// byte port. Assumes index, max packet size and control function bits
// come from neighbouring registers as inputs and strobes last one cycle.
`timescale 1ns/1ns
`include "fifo_port_cfg.svh"
module endpoint_fifo_port import fifo_port_pkg::*; #(
  parameter int NUM_EP = 8,
  parameter int HALF_BYTES = 2048,
  parameter int EPW = $clog2(NUM_EP),
  parameter int OW = $clog2(HALF_BYTES)
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic usb_bus_rst,
  input wire logic [EPW-1:0] ep_index,
  input wire logic [7:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic cpu_byte,
  input wire logic [15:0] cpu_wdata,
  output logic [15:0] cpu_rdata_q,
  input wire logic maxp_wr,
  input wire logic [10:0] max_packet_bytes,
  input wire logic force_in_validate,
  input wire logic force_rx_flush,
  input wire logic dma_mode,
  input wire logic [EPW-1:0] usb_ep,
  input wire logic usb_tx_pop,
  input wire logic usb_tx_done,
  input wire logic usb_rx_push,
  input wire logic [7:0] usb_rx_byte,
  input wire logic usb_rx_ack,
  output logic [7:0] usb_tx_byte_q,
  output logic usb_tx_ready_q,
  output logic [15:0] usb_tx_len_q,
  output logic usb_rx_room_q
);

  // Byte address in the buffer memory: endpoint, half, offset in half
  localparam int AW = EPW + 1 + OW;

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte count that validates a transmit buffer automatically
  function automatic word_t tx_limit(
    input logic [10:0] mps,
    input word_t len,
    input logic dma
  );
    word_t m;
    m = {5'h00, mps};
    if (dma || len == 16'h0000 || len > m) begin
      return m;
    end
    return len;
  endfunction : tx_limit

  // Buffer count to two-bit fill code
  // Two full buffers read as 11, so the 10 code never appears
  function automatic logic [1:0] fill_code(input logic [1:0] n);
    case (n)
      2'h0: return 2'h0;
      2'h1: return 2'h1;
      default: return 2'h3;
    endcase
  endfunction : fill_code

  ////////////////////////////////////////////////////////////////////
  // State
  logic [10:0] fifo_size_field_q [NUM_EP];
  word_t packet_byte_count_q [NUM_EP];
  word_t cnt_q [NUM_EP];
  word_t buf_len_q [NUM_EP][2];
  word_t usb_ptr_q;

  // Tracker and memory outputs
  logic [1:0] cpu_fill;
  logic cpu_half;
  logic [1:0] usb_fill;
  logic usb_half;
  logic cpu_ev;
  logic usb_ev;
  logic [15:0] ram_c_rdata;
  logic [7:0] ram_u_rdata;

  ////////////////////////////////////////////////////////////////////
  // Processor side decode
  logic is_in;
  logic wr_win;
  logic rd_win;
  logic wr_len;
  logic tx_room;
  logic rx_avail;
  word_t cnt;
  word_t cur_len;
  word_t rem;
  word_t lim;
  word_t cnt_nx;
  logic two;
  logic tx_go;
  logic rx_go;
  logic tx_val;
  logic rx_done;
  logic rx_flush;

  // Direction, register hits and the bytes left in the current half
  assign is_in = ep_dir_e'(ep_index[0]) == EP_DIR_IN;
  assign wr_win = cpu_wr && cpu_addr == `FP_OFS_WINDOW;
  assign rd_win = cpu_rd && cpu_addr == `FP_OFS_WINDOW;
  assign wr_len = cpu_wr && cpu_addr == `FP_OFS_LEN;
  assign tx_room = cpu_fill != 2'h2;
  assign rx_avail = cpu_fill != 2'h0;
  assign cnt = cnt_q[ep_index];
  assign cur_len = buf_len_q[ep_index][cpu_half];
  assign rem = cur_len - cnt;
  assign lim = tx_limit(fifo_size_field_q[ep_index], packet_byte_count_q[ep_index], dma_mode);

  // Word writes always step two; word reads step two only when two bytes remain, else one
  always_comb begin
    two = 1'b0;
    if (wr_win) begin
      two = !cpu_byte;
    end else if (rd_win) begin
      two = !cpu_byte && rem >= 16'h0002;
    end
  end

  assign cnt_nx = cnt + (two ? 16'h0002 : 16'h0001);
  assign tx_go = is_in && tx_room && wr_win;
  assign rx_go = !is_in && rx_avail && rd_win;

  // Full size or programmed short size, or the validate flag
  assign tx_val = is_in && tx_room &&
    ((tx_go && lim != 16'h0000 && cnt_nx >= lim) ||
    force_in_validate);
  assign rx_done = rx_go && cnt_nx >= cur_len;
  assign rx_flush = !is_in && rx_avail && force_rx_flush;
  assign cpu_ev = tx_val || rx_done || rx_flush;

  ////////////////////////////////////////////////////////////////////
  // Processor byte pointer per endpoint; flush on IN drops a partial fill
  // so that a half-written packet never reaches the USB side
  always_ff @(posedge clk) begin
    if (sys_rst || usb_bus_rst) begin
      for (int e = 0; e < NUM_EP; e++) begin
        cnt_q[e] <= 16'h0000;
      end
    end else if (cpu_ev || force_rx_flush) begin
      cnt_q[ep_index] <= 16'h0000;
    end else if (tx_go || rx_go) begin
      cnt_q[ep_index] <= cnt_nx;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // USB side decode
  logic usb_in;
  logic u_tx_ok;
  logic u_rx_ok;
  logic u_pop;
  logic u_push;
  logic u_done;
  logic u_ack;

  // Pulses that break the fill rules are dropped, never queued
  assign usb_in = ep_dir_e'(usb_ep[0]) == EP_DIR_IN;
  assign u_tx_ok = usb_in && usb_fill != 2'h0;
  assign u_rx_ok = !usb_in && usb_fill != 2'h2;
  assign u_pop = usb_tx_pop && u_tx_ok;
  assign u_push = usb_rx_push && u_rx_ok;
  assign u_done = usb_tx_done && u_tx_ok;
  assign u_ack = usb_rx_ack && u_rx_ok;
  assign usb_ev = u_done || u_ack;

  // One transaction at a time, so a single USB byte pointer serves all
  always_ff @(posedge clk) begin
    if (sys_rst || usb_bus_rst) begin
      usb_ptr_q <= 16'h0000;
    end else if (usb_ev) begin
      usb_ptr_q <= 16'h0000;
    end else if (u_pop || u_push) begin
      usb_ptr_q <= usb_ptr_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Length of each filled half, written by whichever side produced it
  always_ff @(posedge clk) begin
    if (sys_rst || usb_bus_rst) begin
      for (int e = 0; e < NUM_EP; e++) begin
        buf_len_q[e][0] <= 16'h0000;
        buf_len_q[e][1] <= 16'h0000;
      end
    end else begin
      if (tx_val) begin
        buf_len_q[ep_index][cpu_half] <= tx_go ? cnt_nx : cnt;
      end
      if (u_ack) begin
        buf_len_q[usb_ep][usb_half] <= usb_ptr_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // FIFO size per endpoint, held here for the auto-validate limit
  // Sizes above HALF_BYTES are not checked here
  always_ff @(posedge clk) begin
    if (sys_rst || usb_bus_rst) begin
      for (int e = 0; e < NUM_EP; e++) begin
        fifo_size_field_q[e] <= 11'h000;
      end
    end else if (maxp_wr) begin
      fifo_size_field_q[ep_index] <= max_packet_bytes;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Packet length register; a receive acknowledge wins over a write
  // A byte write changes the low lane only; the upper byte is kept
  always_ff @(posedge clk) begin
    if (sys_rst || usb_bus_rst) begin
      for (int e = 0; e < NUM_EP; e++) begin
        packet_byte_count_q[e] <= `FP_LEN_RST;
      end
    end else begin
      if (maxp_wr) begin
        packet_byte_count_q[ep_index] <= {5'h00, max_packet_bytes};
      end else if (wr_len && cpu_byte) begin
        packet_byte_count_q[ep_index][7:0] <= cpu_wdata[7:0];
      end else if (wr_len) begin
        packet_byte_count_q[ep_index] <= cpu_wdata;
      end
      if (u_ack) begin
        packet_byte_count_q[usb_ep] <= usb_ptr_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Processor read data; held until the next read
  // A refused window read gives zero and leaves the pointer alone
  logic [15:0] win_data;
  logic [1:0] fill_rd;

  assign win_data = two ? ram_c_rdata : {8'h00, ram_c_rdata[7:0]};
  // Data endpoints only; the control pair reads as empty
  assign fill_rd = ep_index < EPW'(`FP_CTRL_EPS) ? 2'h0 : fill_code(cpu_fill);

  always_ff @(posedge clk) begin
    if (sys_rst || usb_bus_rst) begin
      cpu_rdata_q <= `FP_WINDOW_RST;
    end else if (cpu_rd) begin
      case (cpu_addr)
        `FP_OFS_LEN: cpu_rdata_q <= packet_byte_count_q[ep_index];
        `FP_OFS_FILL: cpu_rdata_q <= {14'h0000, fill_rd};
        `FP_OFS_WINDOW: cpu_rdata_q <= rx_go ? win_data : 16'h0000;
        default: cpu_rdata_q <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // USB side outputs, registered one cycle behind the endpoint select
  // The USB side must allow one cycle after changing usb_ep
  always_ff @(posedge clk) begin
    if (sys_rst || usb_bus_rst) begin
      usb_tx_byte_q <= 8'h00;
      usb_tx_ready_q <= 1'b0;
      usb_tx_len_q <= 16'h0000;
      usb_rx_room_q <= 1'b0;
    end else begin
      if (u_pop) begin
        usb_tx_byte_q <= ram_u_rdata;
      end
      usb_tx_ready_q <= u_tx_ok;
      usb_tx_len_q <= buf_len_q[usb_ep][usb_half];
      usb_rx_room_q <= u_rx_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Buffer bookkeeping and storage
  ep_buffer_tracker #(
    .NUM_EP(NUM_EP),
    .EPW(EPW)
  ) i_ep_buffer_tracker (
    .clk(clk),
    .sys_rst(sys_rst),
    .usb_bus_rst(usb_bus_rst),
    .cpu_ep(ep_index),
    .cpu_ev(cpu_ev),
    .usb_ep(usb_ep),
    .usb_ev(usb_ev),
    .cpu_fill(cpu_fill),
    .cpu_half(cpu_half),
    .usb_fill(usb_fill),
    .usb_half(usb_half)
  );

  // Wrap past HALF_BYTES is not guarded; sizes above it corrupt data
  // A word access writes or reads two neighbouring bytes at once
  fifo_byte_ram #(
    .AW(AW)
  ) i_fifo_byte_ram (
    .clk(clk),
    .c_addr({ep_index, cpu_half, cnt[OW-1:0]}),
    .c_we(tx_go),
    .c_two(two),
    .c_wdata(cpu_wdata),
    .c_rdata(ram_c_rdata),
    .u_addr({usb_ep, usb_half, usb_ptr_q[OW-1:0]}),
    .u_we(u_push),
    .u_wdata(usb_rx_byte),
    .u_rdata(ram_u_rdata)
  );

endmodule : endpoint_fifo_port

/* bench/endpoint_fifo_port_sva.sv */
// Checker for the FIFO port's register reads and USB status flags.
// Assumes one clk domain with both resets synchronous and active high.
`timescale 1ns/1ns
module endpoint_fifo_port_chk #(
  parameter int EPW = 3
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic usb_bus_rst,
  input wire logic [EPW-1:0] ep_index,
  input wire logic [7:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic maxp_wr,
  input wire logic [10:0] max_packet_bytes,
  input wire logic usb_rx_ack,
  input wire logic [EPW-1:0] usb_ep,
  input wire logic [15:0] cpu_rdata_q,
  input wire logic usb_tx_ready_q,
  input wire logic [15:0] usb_tx_len_q,
  input wire logic usb_rx_room_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || usb_bus_rst);
  ////////////////////////////////////////////////////////////
  // Bus reset checked while it is high, so it cannot disable itself
  property p_brst_len; disable iff (1'b0) usb_bus_rst |=> usb_tx_len_q == 16'h0000; endproperty
  a_brst_len: assert property (p_brst_len) else $error("length kept");
  property p_ctl_fill;
    cpu_rd && cpu_addr == 8'h1e && ep_index[EPW-1:1] == '0 |=> cpu_rdata_q == 16'h0000;
  endproperty
  a_ctl_fill: assert property (p_ctl_fill) else $error("control fill");
  property p_fill_code;
    cpu_rd && cpu_addr == 8'h1e |=> cpu_rdata_q[15:2] == 14'h0000 && cpu_rdata_q[1:0] != 2'h2;
  endproperty
  a_fill_code: assert property (p_fill_code) else $error("fill code");
  property p_unmapped;
    cpu_rd && !(cpu_addr inside {8'h1c, 8'h1e, 8'h20}) |=> cpu_rdata_q == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_hold; !cpu_rd |=> $stable(cpu_rdata_q); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_in_read;
    cpu_rd && cpu_addr == 8'h20 && ep_index[0] |=> cpu_rdata_q == 16'h0000;
  endproperty
  a_in_read: assert property (p_in_read) else $error("IN window read");
  property p_tx_dir; usb_tx_ready_q |-> $past(usb_ep[0]); endproperty
  a_tx_dir: assert property (p_tx_dir) else $error("ready on OUT");
  property p_rx_dir; usb_rx_room_q |-> !$past(usb_ep[0]); endproperty
  a_rx_dir: assert property (p_rx_dir) else $error("room on IN");
  // Quiet window of two cycles so no other writer touches the length
  property p_maxp_len;
    maxp_wr && !cpu_wr && !usb_rx_ack ##1 (!cpu_wr && !usb_rx_ack && !maxp_wr &&
      $stable(ep_index) && $stable(max_packet_bytes))[*2] ##0 (cpu_rd && cpu_addr == 8'h1c)
      |=> cpu_rdata_q == {5'h00, $past(max_packet_bytes)};
  endproperty
  a_maxp_len: assert property (p_maxp_len) else $error("length not reloaded");
endmodule : endpoint_fifo_port_chk
bind endpoint_fifo_port endpoint_fifo_port_chk #(.EPW(EPW)) i_endpoint_fifo_port_chk (.clk,
  .sys_rst, .usb_bus_rst, .ep_index, .cpu_addr, .cpu_wr, .cpu_rd, .maxp_wr, .max_packet_bytes,
  .usb_rx_ack, .usb_ep, .cpu_rdata_q, .usb_tx_ready_q, .usb_tx_len_q, .usb_rx_room_q);

/* bench/cpu_bus_model.sv */
// Microcontroller model on the register bus of the FIFO port.
// Assumes strobes are taken on a rising edge and read data holds.
`timescale 1ns/1ns
module cpu_bus_model (
  input wire logic clk,
  output logic [2:0] ep_index,
  output logic [7:0] cpu_addr,
  output logic cpu_wr,
  output logic cpu_rd,
  output logic cpu_byte,
  output logic [15:0] cpu_wdata,
  input wire logic [15:0] cpu_rdata_q
);
  // Idle bus from time zero
  initial begin
    ep_index = 3'h0;
    cpu_addr = 8'h00;
    {cpu_wr, cpu_rd, cpu_byte} = 3'b000;
    cpu_wdata = 16'h0000;
  end
  ////////////////////////////////////////////////////////////
  // 48 cycles cover both settle times after an index change
  task sel(input logic [2:0] e);
    @(posedge clk);
    #1 ep_index = e;
    repeat (48) @(posedge clk);
    #1;
  endtask : sel
  // Released data is inverted so a stale value never passes for fresh
  task acc(input logic w, input logic b, input logic [7:0] a, input logic [15:0] d,
    output logic [15:0] q);
    if (!w && a == 8'h1e) repeat (50) @(posedge clk);
    @(posedge clk);
    #1 cpu_addr = a;
    {cpu_wr, cpu_rd, cpu_byte} = {w, !w, b};
    cpu_wdata = d;
    @(posedge clk);
    #1 {cpu_wr, cpu_rd} = 2'b00;
    cpu_wdata = ~d;
    @(posedge clk);
    #1 q = cpu_rdata_q;
  endtask : acc
endmodule : cpu_bus_model

/* bench/endpoint_fifo_port_tb_top.sv */
// Testbench: CPU model on the registers, USB side driven as pulses.
// Assumes one-cycle strobes and status outputs lagging by one cycle.
`timescale 1ns/1ns
module endpoint_fifo_port_tb_top;
  localparam logic [7:0] POP = 8'h01, DONE = 8'h02, PUSH = 8'h04, ACK = 8'h08;
  localparam logic [7:0] MAXP = 8'h10, VAL = 8'h20, FLS = 8'h40, BRST = 8'h80;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic dma_mode = 1'b0;
  logic [7:0] pls = 8'h00;
  logic [10:0] mpb = 11'h000;
  logic [2:0] usb_ep = 3'h0;
  logic [7:0] usb_rx_byte = 8'h00;
  logic [2:0] ep_index;
  logic [7:0] cpu_addr, usb_tx_byte_q;
  logic cpu_wr, cpu_rd, cpu_byte, usb_tx_ready_q, usb_rx_room_q;
  logic [15:0] cpu_wdata, cpu_rdata_q, usb_tx_len_q;
  int fail_count = 0;
  int compares = 0;
  always #2 clk = ~clk;
  cpu_bus_model i_cpu_bus_model (.clk, .ep_index, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_byte,
    .cpu_wdata, .cpu_rdata_q);
  endpoint_fifo_port i_endpoint_fifo_port (.clk, .sys_rst, .usb_bus_rst(pls[7]), .ep_index,
    .cpu_addr, .cpu_wr, .cpu_rd, .cpu_byte, .cpu_wdata, .cpu_rdata_q, .maxp_wr(pls[4]),
    .max_packet_bytes(mpb), .force_in_validate(pls[5]), .force_rx_flush(pls[6]), .dma_mode,
    .usb_ep, .usb_tx_pop(pls[0]), .usb_tx_done(pls[1]), .usb_rx_push(pls[2]), .usb_rx_byte,
    .usb_rx_ack(pls[3]), .usb_tx_byte_q, .usb_tx_ready_q, .usb_tx_len_q, .usb_rx_room_q);
  ////////////////////////////////////////////////////////////
  task wrap_up;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask : chk
  // One-cycle pulse on the USB side or control strobes
  task up(input logic [7:0] m);
    @(posedge clk);
    #1 pls = m;
    @(posedge clk);
    #1 pls = 8'h00;
  endtask : up
  task wr(input logic [7:0] a, input logic [15:0] d, input logic b);
    logic [15:0] q;
    i_cpu_bus_model.acc(1'b1, b, a, d, q);
  endtask : wr
  task rc(input logic [7:0] a, input string n, input logic [15:0] e);
    logic [15:0] q;
    i_cpu_bus_model.acc(1'b0, 1'b0, a, 16'h0000, q);
    chk(n, e, q);
  endtask : rc
  // Status flags lag by a cycle behind the fill update
  task rdy(input logic e);
    repeat (2) @(posedge clk);
    #1 chk("tx ready", 16'(e), 16'(usb_tx_ready_q));
  endtask : rdy
  task maxp(input logic [10:0] n);
    mpb = n;
    up(MAXP);
  endtask : maxp
  task pops(input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      up(POP);
      @(posedge clk);
      #1 chk("tx byte", 16'(v[8*i +: 8]), 16'(usb_tx_byte_q));
    end
    up(DONE);
  endtask : pops
  task push(input logic [23:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      usb_rx_byte = v[8*i +: 8];
      up(PUSH);
    end
    up(ACK);
  endtask : push
  ////////////////////////////////////////////////////////////
  task s_regs;
    i_cpu_bus_model.sel(3'h5);
    rc(8'h1c, "len rst", 16'h0000);
    rc(8'h1e, "fill rst", 16'h0000);
    wr(8'h1c, 16'h1234, 1'b0);
    rc(8'h1c, "len rw", 16'h1234);
    wr(8'h1c, 16'hab56, 1'b1);
    rc(8'h1c, "len byte", 16'h1256);
    wr(8'h10, 16'hffff, 1'b0);
    rc(8'h10, "unmapped", 16'h0000);
    i_cpu_bus_model.sel(3'h1);
    maxp(11'h002);
    wr(8'h20, 16'h4321, 1'b0);
    rc(8'h1e, "ctl fill", 16'h0000);
  endtask : s_regs
  task s_tx;
    i_cpu_bus_model.sel(3'h3);
    usb_ep = 3'h3;
    maxp(11'h004);
    rc(8'h1c, "len max", 16'h0004);
    rc(8'h20, "in read", 16'h0000);
    wr(8'h20, 16'hb2a1, 1'b0);
    wr(8'h20, 16'heec3, 1'b1);
    rdy(1'b0);
    wr(8'h20, 16'h77d4, 1'b1);
    rdy(1'b1);
    wr(8'h20, 16'h6655, 1'b0);
    wr(8'h20, 16'h8877, 1'b0);
    rc(8'h1e, "fill two", 16'h0003);
    pops(32'hd4c3b2a1, 4);
    rc(8'h1e, "fill one", 16'h0001);
    pops(32'h88776655, 4);
  endtask : s_tx
  task s_short;
    wr(8'h1c, 16'h0003, 1'b0);
    wr(8'h20, 16'h2211, 1'b0);
    wr(8'h20, 16'h0033, 1'b1);
    rdy(1'b1);
    chk("tx len", 16'h0003, usb_tx_len_q);
    pops(32'h00332211, 3);
    wr(8'h1c, 16'h0000, 1'b0);
    wr(8'h20, 16'h0044, 1'b1);
    rdy(1'b0);
    up(VAL);
    rdy(1'b1);
    pops(32'h00000044, 1);
    dma_mode = 1'b1;
    wr(8'h1c, 16'h0002, 1'b0);
    wr(8'h20, 16'h6655, 1'b0);
    rdy(1'b0);
    wr(8'h20, 16'h8877, 1'b0);
    rdy(1'b1);
    pops(32'h88776655, 4);
    dma_mode = 1'b0;
  endtask : s_short
  task s_rx;
    i_cpu_bus_model.sel(3'h2);
    usb_ep = 3'h2;
    repeat (2) @(posedge clk);
    #1 chk("rx room", 16'h0001, 16'(usb_rx_room_q));
    push(24'h332211, 3);
    rc(8'h1c, "rx len", 16'h0003);
    rc(8'h1e, "rx fill", 16'h0001);
    rc(8'h20, "rx word", 16'h2211);
    rc(8'h20, "rx odd", 16'h0033);
    rc(8'h1e, "rx clear", 16'h0000);
    rc(8'h20, "rx empty", 16'h0000);
    push(24'h005544, 2);
    up(FLS);
    rc(8'h1e, "flush", 16'h0000);
    rc(8'h20, "flushed", 16'h0000);
    push(24'h000066, 1);
    up(BRST);
    rc(8'h1c, "brst len", 16'h0000);
  endtask : s_rx
  ////////////////////////////////////////////////////////////
  // Main sequence after 20 cycles of reset
  initial begin
    repeat (20) @(posedge clk);
    #1 sys_rst = 1'b0;
    s_regs;
    s_tx;
    s_short;
    s_rx;
    wrap_up;
  end
  // Watchdog in case the sequence hangs
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    wrap_up;
  end
endmodule : endpoint_fifo_port_tb_top
